// >>> common/mds_pkg.sv
// shared constants and types for the moisture detect switch control ends
package mds_pkg;
    // register word size and addresses on the link
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;
    localparam logic [ADDR_W-1:0] OFS_CONTROL = 4'h0;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h1;
    localparam logic [ADDR_W-1:0] OFS_MOIST_LOC = 4'h2;
    localparam logic [ADDR_W-1:0] OFS_INTERRUPT = 4'h3;
    localparam logic [ADDR_W-1:0] OFS_SWITCH = 4'h4;
    // control register fields
    localparam int CTL_CC_EN = 0;
    localparam int CTL_SBU_EN = 1;
    localparam int CTL_AUTO_DRY = 2;
    localparam int CTL_SM_RESET = 3;
    localparam logic [DATA_W-1:0] CTL_ENABLES = 8'h03;
    // status register fields
    localparam int STS_IDLE = 0;
    localparam int STS_CC_SEARCH = 1;
    localparam int STS_SBU_SEARCH = 2;
    localparam int STS_DRY_SEARCH = 3;
    localparam int STS_HALTED = 4;
    // moisture location fields
    localparam int LOC_CC1 = 0;
    localparam int LOC_CC2 = 1;
    localparam int LOC_SBU1 = 2;
    localparam int LOC_SBU2 = 3;
    // interrupt register fields
    localparam int INT_TIMER = 0;
    localparam int INT_MOIST = 1;
    localparam int INT_DRY = 2;
    // switch readback fields
    localparam int SW_FM_SBU1 = 0;
    localparam int SW_SBU1 = 1;
    localparam int SW_SBU2 = 2;
    // reset values
    localparam logic [DATA_W-1:0] RST_CONTROL = 8'h00;
    localparam logic [DATA_W-1:0] RST_INTERRUPT = 8'h00;
    localparam logic [DATA_W-1:0] RST_MOIST_LOC = 8'h00;
    localparam logic [2:0] RST_SWITCH = 3'h0;

    // detection sequencer states
    typedef enum logic [2:0] {
        MDS_IDLE,
        MDS_CC_SEARCH,
        MDS_SBU_SEARCH,
        MDS_DRY_SEARCH,
        MDS_HALTED
    } mds_state_t;
endpackage : mds_pkg

// >>> common/mds_link_if.sv
// register link and open-drain interrupt line between host and device
`timescale 1ns/1ns
interface mds_link_if;
    logic [mds_pkg::ADDR_W-1:0] reg_addr;
    logic [mds_pkg::DATA_W-1:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [mds_pkg::DATA_W-1:0] reg_rdata;
    logic irq_o;
    logic irq_oe;
    logic irq_line;

    // external pull-up: line is high unless the device pulls it down
    assign irq_line = irq_oe ? irq_o : 1'b1;

    modport dev (
        input reg_addr, reg_wdata, reg_wr, reg_rd,
        output reg_rdata, irq_o, irq_oe
    );
    modport host (
        output reg_addr, reg_wdata, reg_wr, reg_rd,
        input reg_rdata, irq_line
    );
endinterface : mds_link_if

// >>> rtl/mds_device.sv
// moisture detect sequencer, register file and sideband switch defaults
`timescale 1ns/1ns
module mds_device (
    // clock and reset
    input wire logic CORE_CLK,
    input wire logic RST,
    // register link and interrupt line
    mds_link_if.dev LINK,
    // factory mode strap, high when left floating
    input wire logic FACTORY_MODE_STRAP,
    // analog front end results
    input wire logic CC_TOGGLE_TIMEOUT,
    input wire logic [1:0] CC_MOIST,
    input wire logic [1:0] SBU_MOIST,
    input wire logic DRY_DETECT,
    // sideband switch controls, high closes the path
    output logic SW_FM_SBU1,
    output logic SW_SBU1_HOST,
    output logic SW_SBU2_HOST,
    // detection comparators enable
    output logic CC_DET_ON,
    output logic SBU_DET_ON,
    output logic DRY_DET_ON
);
    typedef struct packed {
        mds_pkg::mds_state_t state;
        logic [mds_pkg::DATA_W-1:0] control;
        logic [mds_pkg::DATA_W-1:0] int_flags;
        logic [mds_pkg::DATA_W-1:0] moist_loc;
        logic [mds_pkg::DATA_W-1:0] rdata;
        logic [2:0] sw;
        logic strap_taken;
    } mds_dev_state_t;

    mds_dev_state_t st_r;
    mds_dev_state_t st_nxt;

    // status word built from the sequencer state
    function automatic logic [mds_pkg::DATA_W-1:0] status_word(mds_pkg::mds_state_t s);
        logic [mds_pkg::DATA_W-1:0] w;
        w = '0;
        case (s)
            mds_pkg::MDS_IDLE: w[mds_pkg::STS_IDLE] = 1'b1;
            mds_pkg::MDS_CC_SEARCH: w[mds_pkg::STS_CC_SEARCH] = 1'b1;
            mds_pkg::MDS_SBU_SEARCH: w[mds_pkg::STS_SBU_SEARCH] = 1'b1;
            mds_pkg::MDS_DRY_SEARCH: w[mds_pkg::STS_DRY_SEARCH] = 1'b1;
            mds_pkg::MDS_HALTED: w[mds_pkg::STS_HALTED] = 1'b1;
            default: w = '0;
        endcase
        return w;
    endfunction : status_word

    logic wr_ctl;
    logic rd_int;
    logic cc_en;
    logic sbu_en;
    logic auto_dry;
    logic moist_cc;
    logic moist_sbu;
    logic [mds_pkg::DATA_W-1:0] int_set;

    // register strobes decoded once
    assign wr_ctl = LINK.reg_wr && (LINK.reg_addr == mds_pkg::OFS_CONTROL);
    assign rd_int = LINK.reg_rd && (LINK.reg_addr == mds_pkg::OFS_INTERRUPT);
    assign cc_en = st_r.control[mds_pkg::CTL_CC_EN];
    assign sbu_en = st_r.control[mds_pkg::CTL_SBU_EN];
    assign auto_dry = st_r.control[mds_pkg::CTL_AUTO_DRY];
    assign moist_cc = |CC_MOIST;
    assign moist_sbu = |SBU_MOIST;

    // next state of the whole block
    always_comb begin
        st_nxt = st_r;
        int_set = '0;

        // strap is caught on the first clock after reset release
        if (!st_r.strap_taken) begin
            st_nxt.strap_taken = 1'b1;
            if (FACTORY_MODE_STRAP) begin
                st_nxt.sw = 3'b001;
            end else begin
                st_nxt.sw = 3'b110;
            end
        end

        // host writes of control; sm reset bit never stores
        if (wr_ctl) begin
            st_nxt.control = LINK.reg_wdata;
            st_nxt.control[mds_pkg::CTL_SM_RESET] = 1'b0;
        end

        // detection sequencer
        case (st_r.state)
            mds_pkg::MDS_IDLE: begin
                if (cc_en) begin
                    st_nxt.state = mds_pkg::MDS_CC_SEARCH;
                end else if (sbu_en) begin
                    st_nxt.state = mds_pkg::MDS_SBU_SEARCH;
                end
            end
            mds_pkg::MDS_CC_SEARCH: begin
                if (moist_cc) begin
                    st_nxt.moist_loc[mds_pkg::LOC_CC1] = CC_MOIST[0];
                    st_nxt.moist_loc[mds_pkg::LOC_CC2] = CC_MOIST[1];
                    int_set[mds_pkg::INT_MOIST] = 1'b1;
                    st_nxt.state = auto_dry ? mds_pkg::MDS_DRY_SEARCH
                                            : mds_pkg::MDS_HALTED;
                end else if (CC_TOGGLE_TIMEOUT) begin
                    int_set[mds_pkg::INT_TIMER] = 1'b1;
                    st_nxt.state = mds_pkg::MDS_SBU_SEARCH;
                end
            end
            mds_pkg::MDS_SBU_SEARCH: begin
                if (moist_sbu) begin
                    st_nxt.moist_loc[mds_pkg::LOC_SBU1] = SBU_MOIST[0];
                    st_nxt.moist_loc[mds_pkg::LOC_SBU2] = SBU_MOIST[1];
                    int_set[mds_pkg::INT_MOIST] = 1'b1;
                    st_nxt.state = auto_dry ? mds_pkg::MDS_DRY_SEARCH
                                            : mds_pkg::MDS_HALTED;
                end
            end
            mds_pkg::MDS_DRY_SEARCH: begin
                if (DRY_DETECT) begin
                    int_set[mds_pkg::INT_DRY] = 1'b1;
                    st_nxt.state = mds_pkg::MDS_HALTED;
                end
            end
            mds_pkg::MDS_HALTED: begin
                st_nxt.state = mds_pkg::MDS_HALTED;
            end
            default: st_nxt.state = mds_pkg::MDS_IDLE;
        endcase

        // dropping every enable stops the sequencer so a fresh enable restarts it
        if ((st_r.control & mds_pkg::CTL_ENABLES) == '0) begin
            st_nxt.state = mds_pkg::MDS_IDLE;
        end

        // sm reset wins over everything in the sequencer but its interrupt flags, and waits for a new enable
        if (wr_ctl && LINK.reg_wdata[mds_pkg::CTL_SM_RESET]) begin
            st_nxt.state = mds_pkg::MDS_IDLE;
            st_nxt.control[mds_pkg::CTL_CC_EN] = 1'b0;
            st_nxt.control[mds_pkg::CTL_SBU_EN] = 1'b0;
            st_nxt.moist_loc = mds_pkg::RST_MOIST_LOC;
        end

        // read clears the flags, but an event in the same cycle survives
        if (rd_int) begin
            st_nxt.int_flags = int_set;
        end else begin
            st_nxt.int_flags = st_r.int_flags | int_set;
        end

        // read data registered, valid the cycle after the strobe
        st_nxt.rdata = '0;
        if (LINK.reg_rd) begin
            case (LINK.reg_addr)
                mds_pkg::OFS_CONTROL: st_nxt.rdata = st_r.control;
                mds_pkg::OFS_STATUS: st_nxt.rdata = status_word(st_r.state);
                mds_pkg::OFS_MOIST_LOC: st_nxt.rdata = st_r.moist_loc;
                mds_pkg::OFS_INTERRUPT: st_nxt.rdata = st_r.int_flags;
                mds_pkg::OFS_SWITCH: st_nxt.rdata = {5'h00, st_r.sw};
                default: st_nxt.rdata = '0; // unmapped reads as zero
            endcase
        end
    end

    // single register bank for all state
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            st_r.state <= mds_pkg::MDS_IDLE;
            st_r.control <= mds_pkg::RST_CONTROL;
            st_r.int_flags <= mds_pkg::RST_INTERRUPT;
            st_r.moist_loc <= mds_pkg::RST_MOIST_LOC;
            st_r.rdata <= '0;
            st_r.sw <= mds_pkg::RST_SWITCH; // all paths open until the strap is seen
            st_r.strap_taken <= 1'b0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // open drain: only ever drives low, pull-up gives the high level
    assign LINK.irq_o = 1'b0;
    assign LINK.irq_oe = |st_r.int_flags;
    assign LINK.reg_rdata = st_r.rdata;

    // switch and comparator drives
    assign SW_FM_SBU1 = st_r.sw[mds_pkg::SW_FM_SBU1];
    assign SW_SBU1_HOST = st_r.sw[mds_pkg::SW_SBU1];
    assign SW_SBU2_HOST = st_r.sw[mds_pkg::SW_SBU2];
    assign CC_DET_ON = (st_r.state == mds_pkg::MDS_CC_SEARCH);
    assign SBU_DET_ON = (st_r.state == mds_pkg::MDS_SBU_SEARCH);
    assign DRY_DET_ON = (st_r.state == mds_pkg::MDS_DRY_SEARCH);
endmodule : mds_device

// >>> rtl/mds_host.sv
// host end: register access engine, interrupt watch and detection restart
`timescale 1ns/1ns
module mds_host (
    // clock and reset
    input wire logic CORE_CLK,
    input wire logic RST,
    // register link and interrupt line
    mds_link_if.host LINK,
    // user command port
    input wire logic CMD_VALID,
    input wire logic CMD_WRITE,
    input wire logic [mds_pkg::ADDR_W-1:0] CMD_ADDR,
    input wire logic [mds_pkg::DATA_W-1:0] CMD_WDATA,
    output logic CMD_READY,
    // read answer
    output logic RSP_VALID,
    output logic [mds_pkg::DATA_W-1:0] RSP_DATA,
    // restart request: rewrite control with these enables after clearing all
    input wire logic RESTART,
    input wire logic [mds_pkg::DATA_W-1:0] RESTART_CTL,
    // interrupt line seen low
    output logic IRQ_PENDING
);
    typedef enum logic [1:0] {
        MDH_IDLE,
        MDH_READ,
        MDH_REENABLE
    } mds_host_state_t;

    typedef struct packed {
        mds_host_state_t state;
        logic [mds_pkg::ADDR_W-1:0] addr;
        logic [mds_pkg::DATA_W-1:0] wdata;
        logic wr;
        logic rd;
        logic [mds_pkg::DATA_W-1:0] keep_ctl;
        logic rsp_valid;
        logic [mds_pkg::DATA_W-1:0] rsp_data;
        logic irq;
    } mds_host_reg_t;

    mds_host_reg_t h_r;
    mds_host_reg_t h_nxt;

    // one access at a time, so a restart or read in flight blocks commands
    always_comb begin
        h_nxt = h_r;
        h_nxt.wr = 1'b0;
        h_nxt.rd = 1'b0;
        h_nxt.rsp_valid = 1'b0;
        h_nxt.irq = ~LINK.irq_line;
        case (h_r.state)
            MDH_IDLE: begin
                if (RESTART) begin
                    // clear every enable first
                    h_nxt.addr = mds_pkg::OFS_CONTROL;
                    h_nxt.wdata = RESTART_CTL & ~mds_pkg::CTL_ENABLES;
                    h_nxt.wr = 1'b1;
                    h_nxt.keep_ctl = RESTART_CTL;
                    h_nxt.state = MDH_REENABLE;
                end else if (CMD_VALID) begin
                    h_nxt.addr = CMD_ADDR;
                    h_nxt.wdata = CMD_WDATA;
                    h_nxt.wr = CMD_WRITE;
                    h_nxt.rd = ~CMD_WRITE;
                    h_nxt.state = CMD_WRITE ? MDH_IDLE : MDH_READ;
                end
            end
            MDH_READ: begin
                // device answer lands one cycle after the strobe
                if (!h_r.rd) begin
                    h_nxt.rsp_valid = 1'b1;
                    h_nxt.rsp_data = LINK.reg_rdata;
                    h_nxt.state = MDH_IDLE;
                end
            end
            MDH_REENABLE: begin
                // wait a cycle so the device sees the all-clear first
                if (!h_r.wr) begin
                    h_nxt.wdata = h_r.keep_ctl;
                    h_nxt.wr = 1'b1;
                    h_nxt.state = MDH_IDLE;
                end
            end
            default: h_nxt.state = MDH_IDLE;
        endcase
    end

    // single register bank for all state
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            h_r <= '0;
        end else begin
            h_r <= h_nxt;
        end
    end

    // link and user outputs
    assign LINK.reg_addr = h_r.addr;
    assign LINK.reg_wdata = h_r.wdata;
    assign LINK.reg_wr = h_r.wr;
    assign LINK.reg_rd = h_r.rd;
    assign CMD_READY = (h_r.state == MDH_IDLE) && !RESTART;
    assign RSP_VALID = h_r.rsp_valid;
    assign RSP_DATA = h_r.rsp_data;
    assign IRQ_PENDING = h_r.irq;
endmodule : mds_host

// >>> testbench/mds_link_assertions.sv
// assertion checker on the host to device register link
`timescale 1ns/1ns
module mds_link_assertions (
    // clock and reset
    input wire logic CORE_CLK,
    input wire logic RST,
    // link signals
    input wire logic [mds_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [mds_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [mds_pkg::DATA_W-1:0] reg_rdata,
    input wire logic irq_o,
    input wire logic irq_oe
);
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (RST);
    logic smr_r;
    // remembers a state machine reset until the next control write
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            smr_r <= 1'b0;
        end else if (reg_wr && reg_addr == mds_pkg::OFS_CONTROL) begin
            smr_r <= reg_wdata[mds_pkg::CTL_SM_RESET];
        end
    end
    property p_od; irq_oe |-> !irq_o; endproperty
    a_od: assert property (p_od) else $error("line driven high");
    property p_flags; reg_rd && reg_addr == mds_pkg::OFS_INTERRUPT
        |=> (reg_rdata != 8'h00) == $past(irq_oe); endproperty
    a_flags: assert property (p_flags) else $error("flags and line differ");
    property p_hold; irq_oe && !(reg_rd && reg_addr == mds_pkg::OFS_INTERRUPT) |=> irq_oe;
    endproperty
    a_hold: assert property (p_hold) else $error("line released unread");
    property p_rdz; !reg_rd |=> reg_rdata == 8'h00; endproperty
    a_rdz: assert property (p_rdz) else $error("read data not zero");
    property p_onehot; reg_rd && reg_addr == mds_pkg::OFS_STATUS |=> $onehot(reg_rdata);
    endproperty
    a_onehot: assert property (p_onehot) else $error("status not one-hot");
    property p_smr_sts; smr_r && reg_rd && reg_addr == mds_pkg::OFS_STATUS
        |=> reg_rdata == 8'h01; endproperty
    a_smr_sts: assert property (p_smr_sts) else $error("not idle after sm reset");
    property p_smr_loc; smr_r && reg_rd && reg_addr == mds_pkg::OFS_MOIST_LOC
        |=> reg_rdata == 8'h00; endproperty
    a_smr_loc: assert property (p_smr_loc) else $error("location kept");
    property p_unmap; reg_rd && reg_addr > mds_pkg::OFS_SWITCH |=> reg_rdata == 8'h00;
    endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
    property p_rst; $fell(RST) |-> !irq_oe; endproperty
    a_rst: assert property (p_rst) else $error("line low after reset");
endmodule : mds_link_assertions

// >>> testbench/moisture_detect_switch_ctrl_test.sv
// self-checking bench joining host and device ends over the link
`timescale 1ns/1ns
module moisture_detect_switch_ctrl_test;
    logic CORE_CLK = 1'b0;
    logic RST = 1'b1;
    logic strap = 1'b1;
    logic tmo = 1'b0;
    logic dry = 1'b0;
    logic [1:0] ccm = 2'h0;
    logic [1:0] sbm = 2'h0;
    logic cv = 1'b0;
    logic cw = 1'b0;
    logic rs = 1'b0;
    logic [3:0] ca = 4'h0;
    logic [7:0] cd = 8'h00;
    logic rdy, rv, ip, fm1, s1, s2, ccon, sbon, dron;
    logic [7:0] rdat;
    int err_total = 0;
    int samples_checked = 0;
    int m_v;
    logic [7:0] rctl = 8'h02;
    // model of the answers still owed by the host, oldest first
    logic [7:0] exp_q[$];
    mds_link_if u_link ();
    // both ends and the checker on the shared link
    mds_device u_mds_device (.CORE_CLK(CORE_CLK), .RST(RST), .LINK(u_link.dev),
        .FACTORY_MODE_STRAP(strap), .CC_TOGGLE_TIMEOUT(tmo), .CC_MOIST(ccm), .SBU_MOIST(sbm),
        .DRY_DETECT(dry), .SW_FM_SBU1(fm1), .SW_SBU1_HOST(s1), .SW_SBU2_HOST(s2),
        .CC_DET_ON(ccon), .SBU_DET_ON(sbon), .DRY_DET_ON(dron));
    mds_host u_mds_host (.CORE_CLK(CORE_CLK), .RST(RST), .LINK(u_link.host),
        .CMD_VALID(cv), .CMD_WRITE(cw), .CMD_ADDR(ca), .CMD_WDATA(cd), .CMD_READY(rdy),
        .RSP_VALID(rv), .RSP_DATA(rdat), .RESTART(rs), .RESTART_CTL(rctl),
        .IRQ_PENDING(ip));
    mds_link_assertions u_chk (.CORE_CLK(CORE_CLK), .RST(RST), .reg_addr(u_link.reg_addr),
        .reg_wdata(u_link.reg_wdata), .reg_wr(u_link.reg_wr), .reg_rd(u_link.reg_rd),
        .reg_rdata(u_link.reg_rdata), .irq_o(u_link.irq_o), .irq_oe(u_link.irq_oe));
    // free-running core clock
    initial begin
        forever #2 CORE_CLK = ~CORE_CLK;
    end
    task automatic close_out();
        $display("checks %0d errors %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : close_out
    task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask : check
    // every host answer is held against the model; a stray or doubled pulse has no entry
    always @(negedge CORE_CLK) begin
        if (rv === 1'b1) begin
            if (exp_q.size() == 0) begin
                err_total++;
                $display("MISMATCH rsp_count expected 0 seen 1");
            end else begin
                check("rsp_model", exp_q.pop_front(), rdat);
            end
        end
    end
    task automatic tick(input int n);
        repeat (n) @(posedge CORE_CLK);
    endtask : tick
    // waits for ready at a falling edge so the combinational flag has settled
    task automatic issue(input logic w, input logic [3:0] a, input logic [7:0] d);
        int i;
        @(negedge CORE_CLK);
        for (i = 0; i < 50 && rdy !== 1'b1; i++) @(negedge CORE_CLK);
        if (i == 50) begin
            err_total++;
            close_out();
        end
        @(posedge CORE_CLK);
        cv <= 1'b1;
        cw <= w;
        ca <= a;
        cd <= d;
        @(posedge CORE_CLK);
        cv <= 1'b0;
    endtask : issue
    task automatic rd(input string name, input logic [3:0] a, input logic [7:0] exp);
        int i;
        exp_q.push_back(exp);
        issue(1'b0, a, 8'h00);
        for (i = 0; i < 20 && rv !== 1'b1; i++) @(negedge CORE_CLK);
        if (i == 20) begin
            err_total++;
            close_out();
        end
        check(name, exp, rdat);
    endtask : rd
    // one-cycle front end event: 0 timer, 1 cc moisture, 2 sbu moisture, 3 dry
    task automatic event_in(input int k, input logic [1:0] v);
        // a fresh enable needs two edges to reach its search state; earlier events are lost
        tick(3);
        tmo <= (k == 0);
        ccm <= (k == 1) ? v : 2'h0;
        sbm <= (k == 2) ? v : 2'h0;
        dry <= (k == 3);
        @(posedge CORE_CLK);
        {tmo, ccm, sbm, dry} <= 6'h00;
        tick(3);
    endtask : event_in
    // main sequence
    initial begin
        void'($urandom(72));
        tick(2);
        RST <= 1'b0;
        tick(3);
        check("switches", 8'h01, {5'h00, s2, s1, fm1});
        rd("switch", mds_pkg::OFS_SWITCH, 8'h01);
        rd("status", mds_pkg::OFS_STATUS, 8'h01);
        rd("control", mds_pkg::OFS_CONTROL, mds_pkg::RST_CONTROL);
        rd("int", mds_pkg::OFS_INTERRUPT, mds_pkg::RST_INTERRUPT);
        check("line", 8'h01, {7'h00, u_link.irq_line});
        check("pending", 8'h00, {7'h00, ip});
        // second reset in mid-run with the strap grounded, driven on a rising edge
        @(posedge CORE_CLK);
        RST <= 1'b1;
        strap <= 1'b0;
        tick(2);
        RST <= 1'b0;
        tick(3);
        check("switches", 8'h06, {5'h00, s2, s1, fm1});
        issue(1'b1, mds_pkg::OFS_SWITCH, 8'h00);
        rd("switch", mds_pkg::OFS_SWITCH, 8'h06);
        issue(1'b1, mds_pkg::OFS_CONTROL, 8'h05);
        rd("status", mds_pkg::OFS_STATUS, 8'h02);
        check("cc_on", 8'h01, {7'h00, ccon});
        event_in(0, 2'h0);
        check("line", 8'h00, {7'h00, u_link.irq_line});
        check("pending", 8'h01, {7'h00, ip});
        rd("status", mds_pkg::OFS_STATUS, 8'h04);
        check("det_on", 8'h02, {6'h00, sbon, ccon});
        rd("int", mds_pkg::OFS_INTERRUPT, 8'h01);
        check("line", 8'h01, {7'h00, u_link.irq_line});
        m_v = $urandom_range(1, 3);
        event_in(2, m_v[1:0]);
        check("line", 8'h00, {7'h00, u_link.irq_line});
        rd("loc", mds_pkg::OFS_MOIST_LOC, {4'h0, m_v[1:0], 2'h0});
        rd("status", mds_pkg::OFS_STATUS, 8'h08);
        check("dry_on", 8'h01, {7'h00, dron});
        rd("int", mds_pkg::OFS_INTERRUPT, 8'h02);
        check("line", 8'h01, {7'h00, u_link.irq_line});
        event_in(3, 2'h0);
        rd("int", mds_pkg::OFS_INTERRUPT, 8'h04);
        rd("status", mds_pkg::OFS_STATUS, 8'h10);
        // restart through the host: clear enables, then a random enable set
        m_v = $urandom_range(1, 2);
        @(posedge CORE_CLK);
        rctl <= m_v[7:0];
        rs <= 1'b1;
        @(posedge CORE_CLK);
        rs <= 1'b0;
        rd("status", mds_pkg::OFS_STATUS, (m_v == 1) ? 8'h02 : 8'h04);
        rd("control", mds_pkg::OFS_CONTROL, m_v[7:0]);
        issue(1'b1, mds_pkg::OFS_CONTROL, 8'h08);
        rd("status", mds_pkg::OFS_STATUS, 8'h01);
        rd("loc", mds_pkg::OFS_MOIST_LOC, mds_pkg::RST_MOIST_LOC);
        rd("control", mds_pkg::OFS_CONTROL, 8'h00);
        issue(1'b1, mds_pkg::OFS_CONTROL, 8'h01);
        m_v = $urandom_range(1, 3);
        event_in(1, m_v[1:0]);
        rd("loc", mds_pkg::OFS_MOIST_LOC, {6'h00, m_v[1:0]});
        rd("status", mds_pkg::OFS_STATUS, 8'h10);
        rd("int", mds_pkg::OFS_INTERRUPT, 8'h02);
        m_v = $urandom_range(5, 15);
        rd("unmapped", m_v[3:0], 8'h00);
        close_out();
    end
endmodule : moisture_detect_switch_ctrl_test
